// ### pkg/csc_pkg.sv
// constants, field layouts and carrier types of the clock source configuration block
// What this block does
// - group field picks initial oscillator group
// - switch/monitor field gates switching and monitor
// - range bit picks high or low range
// - clock-output bit drives clock on pin two except in crystal mode
// - mode field selects primary oscillator behaviour
// - low byte opens after 46h, 57h
// - high byte opens after 78h, 9Ah
// - PLL multiplier fixed at thirty-two
// - instruction clock is PLL/16 or osc/2
// - ADC clock is PLL output halved
// - PWM clock is undivided PLL output
// - start-up timer counts 1024 oscillator cycles
// - timer applies to crystal on POR, wake
// - lock status follows PLL lock, read-only
// - reset release loads source, mode, pin role
// - external clock: pin one input, pin two osc/2
// - external clock with I/O: pin two GPIO
// - unimplemented group word bits read zero
// - lock reads zero without PLL group
package csc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CFG_W = 24;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_LO = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_HI = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_CFG = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OPT_CFG = 4'h3;
  localparam logic [DATA_W-1:0] KEY_LO_1 = 8'h46;
  localparam logic [DATA_W-1:0] KEY_LO_2 = 8'h57;
  localparam logic [DATA_W-1:0] KEY_HI_1 = 8'h78;
  localparam logic [DATA_W-1:0] KEY_HI_2 = 8'h9A;
  localparam logic [1:0] GRP_FRC = 2'h0;
  localparam logic [1:0] GRP_FRC_PLL = 2'h1;
  localparam logic [1:0] GRP_PRI = 2'h2;
  localparam logic [1:0] GRP_PRI_PLL = 2'h3;
  localparam int unsigned GRP_PLL_BIT = 0;
  localparam int unsigned GRP_PRI_BIT = 1;
  localparam logic [1:0] MODE_EXT = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_XTAL = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam int unsigned LO_CLKLOCK_BIT = 7;
  localparam int unsigned LO_LOCK_BIT = 5;
  localparam int unsigned LO_PRCDEN_BIT = 4;
  localparam int unsigned LO_TSEQEN_BIT = 2;
  localparam int unsigned LO_OSWEN_BIT = 0;
  localparam int unsigned HI_COSC_LSB = 4;
  localparam int unsigned HI_NOSC_LSB = 0;
  localparam logic [2:0] GRP_LAST_VALID = 3'h3;
  localparam logic [CFG_W-1:0] GROUP_CFG_MASK = 24'h000003;
  localparam logic [CFG_W-1:0] OPT_CFG_MASK = 24'h0000E7;
  localparam logic [5:0] PLL_MULT = 6'h20;
  localparam logic [3:0] INSTR_PLL_DIV = 4'hF;
  localparam logic [3:0] INSTR_OSC_DIV = 4'h1;
  localparam int unsigned OST_CYCLES = 1024;
  localparam int unsigned OST_W = 10;

  typedef struct packed {
    logic [1:0] switch_monitor_sel;
    logic freq_range_sel;
    logic [1:0] unused;
    logic clkout_pin_enable;
    logic [1:0] primary_osc_mode;
  } csc_opts_t;

  typedef struct packed {
    logic o;
    logic oe;
  } csc_pin_t;

  typedef enum logic [1:0] {
    UL_IDLE,
    UL_KEY1,
    UL_OPEN
  } csc_unlock_t;
endpackage

// ### verilog/csc_clock_source_config.sv
// clock source configuration: config capture, control register unlock, clock enables, pins
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module csc_clock_source_config #(
  parameter int unsigned OST_CYCLES = csc_pkg::OST_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [csc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [csc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [csc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [csc_pkg::CFG_W-1:0] cfg_group_word,
  input wire logic [csc_pkg::CFG_W-1:0] cfg_options_word,
  input wire logic osc_in_pin,
  input wire logic frc_tick,
  input wire logic pll_tick,
  input wire logic pll_lock_raw,
  input wire logic wake_pulse,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic osc_out_o,
  output logic osc_out_oe,
  output logic osc_in_clk_en,
  output logic feedback_en,
  output logic freq_range_high,
  output logic switch_enable,
  output logic monitor_enable,
  output logic pll_enable,
  output logic [5:0] pll_mult,
  output logic pwm_clk_en,
  output logic adc_clk_en,
  output logic instr_clk_en,
  output logic osc_released,
  output logic prcd_enable,
  output logic tseq_enable
);
  if (OST_CYCLES != (1 << csc_pkg::OST_W)) begin : g_bad_ost
    $error("start-up count must fill the timer width exactly");
  end

  logic rst_s1_q, rst_n;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // pin and analog inputs; the pin edge is taken from the second and third stages, lock from the second
  logic osc_s1_q, osc_s2_q, osc_s3_q, lock_s1_q, lock_s2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else if (ce) begin
      osc_s1_q <= osc_in_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      lock_s1_q <= pll_lock_raw;
      lock_s2_q <= lock_s1_q;
    end
  end
  logic osc_edge;
  assign osc_edge = osc_s2_q & ~osc_s3_q;

  // configuration words are caught on the first enabled cycle after release
  logic cfg_loaded_q;
  logic [1:0] group_cfg_q;
  csc_pkg::csc_opts_t opts_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_loaded_q <= 1'b0;
      group_cfg_q <= csc_pkg::GRP_FRC;
      opts_q <= '0;
    end else if (ce && !cfg_loaded_q) begin
      cfg_loaded_q <= 1'b1;
      group_cfg_q <= cfg_group_word[1:0];
      opts_q <= csc_pkg::csc_opts_t'(cfg_options_word[7:0]);
    end
  end

  logic xtal_mode, ext_mode, pll_sel, pri_sel;
  assign xtal_mode = opts_q.primary_osc_mode == csc_pkg::MODE_XTAL;
  assign ext_mode = opts_q.primary_osc_mode == csc_pkg::MODE_EXT;

  // unlock sequencing shared by both bytes of the control register
  function automatic csc_pkg::csc_unlock_t unlock_next(csc_pkg::csc_unlock_t st, logic hit,
      logic [csc_pkg::DATA_W-1:0] d, logic [csc_pkg::DATA_W-1:0] k1,
      logic [csc_pkg::DATA_W-1:0] k2);
    csc_pkg::csc_unlock_t nx;
    nx = csc_pkg::UL_IDLE;
    case (st)
      csc_pkg::UL_KEY1: begin
        if (hit && d == k2) begin
          nx = csc_pkg::UL_OPEN;
        end else if (hit && d == k1) begin
          nx = csc_pkg::UL_KEY1;
        end
      end
      // a first key in the open slot is taken as the write and also restarts the sequence
      default: begin
        if (hit && d == k1) begin
          nx = csc_pkg::UL_KEY1;
        end
      end
    endcase
    return nx;
  endfunction

  logic wr_lo, wr_hi, lo_accept, hi_accept;
  csc_pkg::csc_unlock_t lo_st_q, hi_st_q;
  assign wr_lo = reg_wr && reg_addr == csc_pkg::ADDR_CTRL_LO;
  assign wr_hi = reg_wr && reg_addr == csc_pkg::ADDR_CTRL_HI;
  assign lo_accept = wr_lo && lo_st_q == csc_pkg::UL_OPEN;
  assign hi_accept = wr_hi && hi_st_q == csc_pkg::UL_OPEN;

  // every enabled cycle is one instruction slot; a cycle with neither the next key nor a repeated first key closes the door
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lo_st_q <= csc_pkg::UL_IDLE;
    end else if (ce) begin
      lo_st_q <= unlock_next(lo_st_q, wr_lo, reg_wdata, csc_pkg::KEY_LO_1,
                             csc_pkg::KEY_LO_2);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_st_q <= csc_pkg::UL_IDLE;
    end else if (ce) begin
      hi_st_q <= unlock_next(hi_st_q, wr_hi, reg_wdata, csc_pkg::KEY_HI_1,
                             csc_pkg::KEY_HI_2);
    end
  end

  // control register fields
  logic [1:0] cur_grp_q;
  logic [2:0] nosc_q;
  logic clklock_q, prcden_q, tseqen_q, oswen_q;
  assign pll_sel = cur_grp_q[csc_pkg::GRP_PLL_BIT];
  assign pri_sel = cur_grp_q[csc_pkg::GRP_PRI_BIT];
  assign switch_enable = ~opts_q.switch_monitor_sel[1];
  assign monitor_enable = opts_q.switch_monitor_sel == 2'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clklock_q <= 1'b0;
      prcden_q <= 1'b0;
      tseqen_q <= 1'b0;
      oswen_q <= 1'b0;
    end else if (ce) begin
      if (lo_accept) begin
        // lock bit is sticky until reset
        clklock_q <= clklock_q | reg_wdata[csc_pkg::LO_CLKLOCK_BIT];
        prcden_q <= reg_wdata[csc_pkg::LO_PRCDEN_BIT];
        tseqen_q <= reg_wdata[csc_pkg::LO_TSEQEN_BIT];
        oswen_q <= reg_wdata[csc_pkg::LO_OSWEN_BIT];
      end else if (oswen_q) begin
        oswen_q <= 1'b0;
      end
    end
  end

  // with switching disabled the request is dropped and the group stays put
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_grp_q <= csc_pkg::GRP_FRC;
      nosc_q <= 3'h0;
    end else if (ce) begin
      if (!cfg_loaded_q) begin
        cur_grp_q <= cfg_group_word[1:0];
        nosc_q <= {1'b0, cfg_group_word[1:0]};
      end else begin
        if (hi_accept && !(clklock_q && opts_q.switch_monitor_sel[1])) begin
          nosc_q <= reg_wdata[csc_pkg::HI_NOSC_LSB +: 3];
        end
        if (oswen_q && switch_enable && nosc_q <= csc_pkg::GRP_LAST_VALID) begin
          cur_grp_q <= nosc_q[1:0];
        end
      end
    end
  end

  logic lock_bit;
  assign lock_bit = lock_s2_q & pll_sel;

  // register reads, answered one cycle after the strobe
  logic [csc_pkg::DATA_W-1:0] rd_d;
  logic [csc_pkg::CFG_W-1:0] grp_word, opt_word;
  assign grp_word = {22'h0, group_cfg_q} & csc_pkg::GROUP_CFG_MASK;
  assign opt_word = {16'h0, opts_q} & csc_pkg::OPT_CFG_MASK;
  always_comb begin
    rd_d = '0;
    if (reg_addr == csc_pkg::ADDR_CTRL_LO) begin
      rd_d[csc_pkg::LO_CLKLOCK_BIT] = clklock_q;
      rd_d[csc_pkg::LO_LOCK_BIT] = lock_bit;
      rd_d[csc_pkg::LO_PRCDEN_BIT] = prcden_q;
      rd_d[csc_pkg::LO_TSEQEN_BIT] = tseqen_q;
      rd_d[csc_pkg::LO_OSWEN_BIT] = oswen_q;
    end else if (reg_addr == csc_pkg::ADDR_CTRL_HI) begin
      rd_d[csc_pkg::HI_COSC_LSB +: 3] = {1'b0, cur_grp_q};
      rd_d[csc_pkg::HI_NOSC_LSB +: 3] = nosc_q;
    end else if (reg_addr == csc_pkg::ADDR_GROUP_CFG) begin
      rd_d = grp_word[csc_pkg::DATA_W-1:0];
    end else if (reg_addr == csc_pkg::ADDR_OPT_CFG) begin
      rd_d = opt_word[csc_pkg::DATA_W-1:0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_d : '0;
    end
  end

  // start-up timer: restarts at load and on wake, only meaningful for a crystal
  logic [csc_pkg::OST_W-1:0] ost_cnt_q;
  logic ost_done_q, ost_run;
  assign ost_run = xtal_mode && pri_sel;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ost_cnt_q <= '0;
      ost_done_q <= 1'b0;
    end else if (ce) begin
      if (!cfg_loaded_q || wake_pulse) begin
        ost_cnt_q <= '0;
        ost_done_q <= 1'b0;
      end else if (!ost_run) begin
        ost_done_q <= 1'b1;
      end else if (!ost_done_q && osc_edge) begin
        ost_cnt_q <= ost_cnt_q + 1'b1;
        if (ost_cnt_q == csc_pkg::OST_W'(OST_CYCLES - 1)) begin
          ost_done_q <= 1'b1;
        end
      end
    end
  end
  assign osc_released = ost_done_q;

  // derived clock enables; the PLL outputs are gated off while it is not in the group
  logic [3:0] instr_cnt_q, instr_div;
  logic adc_ph_q, pwm_q, adc_q, instr_q, sys_tick, clock_out_q;
  assign sys_tick = pri_sel ? (osc_edge & ost_done_q) : frc_tick;
  assign instr_div = pll_sel ? csc_pkg::INSTR_PLL_DIV : csc_pkg::INSTR_OSC_DIV;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
      adc_q <= 1'b0;
      adc_ph_q <= 1'b0;
    end else if (ce) begin
      pwm_q <= pll_tick & pll_sel;
      adc_q <= pll_tick & pll_sel & adc_ph_q;
      if (pll_tick && pll_sel) begin
        adc_ph_q <= ~adc_ph_q;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      instr_cnt_q <= '0;
      instr_q <= 1'b0;
    end else if (ce) begin
      instr_q <= 1'b0;
      if (pll_sel ? (pll_tick && ost_done_q) : sys_tick) begin
        if (instr_cnt_q >= instr_div) begin
          instr_cnt_q <= '0;
          instr_q <= 1'b1;
        end else begin
          instr_cnt_q <= instr_cnt_q + 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_out_q <= 1'b0;
    end else if (ce && sys_tick) begin
      clock_out_q <= ~clock_out_q;
    end
  end
  assign pwm_clk_en = pwm_q;
  assign adc_clk_en = adc_q;
  assign instr_clk_en = instr_q;
  assign pll_enable = pll_sel;
  assign pll_mult = csc_pkg::PLL_MULT;
  assign freq_range_high = opts_q.freq_range_sel;
  assign prcd_enable = prcden_q;
  assign tseq_enable = tseqen_q;

  // pin roles; in crystal mode both pins belong to the resonator
  csc_pkg::csc_pin_t osc_out_pin;
  always_comb begin
    osc_out_pin = '{o: gpio_out, oe: gpio_oe};
    if (xtal_mode) begin
      osc_out_pin = '{o: 1'b0, oe: 1'b0};
    end else if (opts_q.clkout_pin_enable) begin
      osc_out_pin = '{o: clock_out_q, oe: 1'b1};
    end
  end
  assign osc_out_o = osc_out_pin.o;
  assign osc_out_oe = osc_out_pin.oe;
  assign feedback_en = xtal_mode;
  assign osc_in_clk_en = pri_sel && opts_q.primary_osc_mode != csc_pkg::MODE_OFF;

  sequence s_lo_keys;
    ce && wr_lo && reg_wdata == csc_pkg::KEY_LO_1 ##1 ce && wr_lo && reg_wdata == csc_pkg::KEY_LO_2;
  endsequence
  sequence s_hi_keys;
    ce && wr_hi && reg_wdata == csc_pkg::KEY_HI_1 ##1 ce && wr_hi && reg_wdata == csc_pkg::KEY_HI_2;
  endsequence

  a_lo_unlock_opens: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_lo_keys ##1 ce && wr_lo |-> lo_accept) else $error("low byte not opened by keys");
  a_hi_unlock_opens: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_hi_keys ##1 ce && wr_hi |-> hi_accept) else $error("high byte not opened by keys");
  a_stray_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && lo_accept |-> $past(wr_lo) && $past(reg_wdata) == csc_pkg::KEY_LO_2
      && $past(wr_lo, 2) && $past(reg_wdata, 2) == csc_pkg::KEY_LO_1)
    else $error("low byte accepted without full sequence");
  a_lock_gated_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && reg_rd && reg_addr == csc_pkg::ADDR_CTRL_LO && !pll_sel
      ##1 ce |-> !reg_rdata[csc_pkg::LO_LOCK_BIT]) else $error("lock shown without PLL");
  a_pwm_follows_pll: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && pll_tick && pll_sel |=> pwm_clk_en) else $error("PWM clock missed a PLL tick");
  a_ost_full_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && ost_run && $rose(ost_done_q) |-> $past(ost_cnt_q) == csc_pkg::OST_W'(OST_CYCLES - 1))
    else $error("start-up timer released early");
  a_clock_out_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_loaded_q && ext_mode && opts_q.clkout_pin_enable |-> osc_out_oe && osc_out_o == clock_out_q)
    else $error("clock output not driven");
  a_gpio_pin_role: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_loaded_q && ext_mode && !opts_q.clkout_pin_enable
      |-> osc_out_oe == gpio_oe && !feedback_en) else $error("pin two not handed to GPIO");
  a_cfg_read_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_loaded_q |=> $stable(opts_q) && $stable(group_cfg_q)) else $error("config changed");

  sequence s_pll_two;
    ce && pll_tick && pll_sel ##1 ce && pll_tick && pll_sel;
  endsequence
  sequence s_sys_two;
    ce && !pll_sel && sys_tick ##1 ce && !pll_sel && sys_tick;
  endsequence

  a_adc_half_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pll_two |=> adc_clk_en != $past(adc_clk_en))
    else $error("ADC clock not every second tick");
  a_instr_osc_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_sys_two |=> instr_clk_en != $past(instr_clk_en))
    else $error("instruction clock not half the oscillator");
  a_pll_clocks_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !pll_sel |=> !pwm_clk_en && !adc_clk_en)
    else $error("PLL clocks without PLL group");
  a_switch_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && oswen_q && !switch_enable |=> $stable(cur_grp_q)) else $error("switch while disabled");
  a_wake_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && wake_pulse |=> !osc_released) else $error("wake did not restart timer");
  a_release_direct: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && cfg_loaded_q && !ost_run && !wake_pulse |=> osc_released)
    else $error("non-crystal source held back");
  a_group_at_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !cfg_loaded_q |=> cur_grp_q == $past(cfg_group_word[1:0]))
    else $error("initial group not loaded");
  a_hi_stray_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && hi_accept |-> $past(wr_hi) && $past(reg_wdata) == csc_pkg::KEY_HI_2
      && $past(wr_hi, 2) && $past(reg_wdata, 2) == csc_pkg::KEY_HI_1)
    else $error("high byte accepted without full sequence");
endmodule // csc_clock_source_config

// ### tb/csc_osc_src.sv
// oscillator source on pin one: crystal or CMOS clock, stalls low while stopped
`timescale 1ns/1ps
module csc_osc_src #(
  parameter int HALF_NS = 50
) (
  input wire logic run,
  output logic osc
);
  // odd start offset keeps the pin edges unrelated to the system clock
  initial begin
    osc = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      osc = run ? ~osc : 1'b0;
    end
  end
endmodule // csc_osc_src

// ### tb/csc_clock_source_config_tb.sv
// self-checking bench of the clock source configuration block
`timescale 1ns/1ps
module csc_clock_source_config_tb;
  logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
  logic [23:0] cfg_g = 24'h0, cfg_o = 24'h0;
  logic osc, run = 1'b0, frc_tick = 1'b0, pll_tick = 1'b0, lock_raw = 1'b0;
  logic wake_pulse = 1'b0, gpio_out = 1'b0, gpio_oe = 1'b0, ce = 1'b1;
  logic oo, ooe, in_en, fb_en, rng, sw_en, mon_en, pll_en, pwm, adc, instr, rel, prcd, tseq;
  logic [5:0] mult;
  int n_errors = 0, total_checks = 0;

  csc_osc_src csc_osc_src_i (.run(run), .osc(osc));
  csc_clock_source_config csc_clock_source_config_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_group_word(cfg_g), .cfg_options_word(cfg_o),
    .osc_in_pin(osc), .frc_tick(frc_tick), .pll_tick(pll_tick), .pll_lock_raw(lock_raw),
    .wake_pulse(wake_pulse), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .osc_out_o(oo),
    .osc_out_oe(ooe), .osc_in_clk_en(in_en), .feedback_en(fb_en), .freq_range_high(rng),
    .switch_enable(sw_en), .monitor_enable(mon_en), .pll_enable(pll_en), .pll_mult(mult),
    .pwm_clk_en(pwm), .adc_clk_en(adc), .instr_clk_en(instr), .osc_released(rel),
    .prcd_enable(prcd), .tseq_enable(tseq));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // strobe stays up between back-to-back writes; idle or rd drops it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic rst(input logic [23:0] g, input logic [23:0] o);
    arst_n <= 1'b0;
    cfg_g <= g;
    cfg_o <= o;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // counts pulses of {instr, adc, pwm}[k] over n cycles
  task automatic cnt(input int k, input int n, input int exp);
    int c;
    logic [2:0] v;
    c = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 v = {instr, adc, pwm};
      c += v[k];
    end
    @(posedge clk_sys);
    chk(8'(c), 8'(exp));
  endtask

  task automatic t_ext_pll();
    rst(24'hFFFFF3, 24'hFFFF7C);
    chk({rng, sw_en, mon_en, pll_en, in_en, fb_en, ooe}, 7'b1101101);
    chk({2'b0, mult}, 8'h20);
    rd(4'h2); chk(rd_v, 8'h03);
    rd(4'h3); chk(rd_v, 8'h64);
    rd(4'h1); chk({5'h0, rd_v[6:4]}, 8'h03);
    pll_tick <= 1'b1;
    cnt(0, 64, 64);
    cnt(1, 64, 32);
    cnt(2, 64, 4);
    wr(4'h2, 8'h00); idle(1); rd(4'h2); chk(rd_v, 8'h03);
    rd(4'h7); chk(rd_v, 8'h00);
  endtask

  task automatic t_unlock();
    // keys offered while the block is frozen must not count
    ce <= 1'b0;
    wr(4'h0, 8'h46); wr(4'h0, 8'h57); wr(4'h0, 8'h14); idle(1);
    ce <= 1'b1;
    idle(1);
    chk({prcd, tseq}, 2'b00);
    wr(4'h0, 8'h46); wr(4'h0, 8'h57); wr(4'h0, 8'h14); idle(2);
    chk({prcd, tseq}, 2'b11);
    wr(4'h0, 8'h46); rd(4'h0); wr(4'h0, 8'h57); wr(4'h0, 8'h00); idle(2);
    chk({prcd, tseq}, 2'b11);
    wr(4'h0, 8'h46); wr(4'h0, 8'h57); idle(1); wr(4'h0, 8'h00); idle(2);
    chk({prcd, tseq}, 2'b11);
    lock_raw <= 1'b1; idle(5); rd(4'h0); chk(rd_v, 8'h34);
    lock_raw <= 1'b0; idle(5); rd(4'h0); chk(rd_v, 8'h14);
    lock_raw <= 1'b1;
    wr(4'h1, 8'h78); wr(4'h1, 8'h9A); wr(4'h1, 8'h02);
    wr(4'h0, 8'h46); wr(4'h0, 8'h57); wr(4'h0, 8'h15); idle(4);
    rd(4'h1); chk(rd_v, 8'h22);
    rd(4'h0); chk(rd_v, 8'h14);
    chk({7'h0, pll_en}, 8'h00);
    cnt(0, 32, 0);
  endtask

  task automatic t_frc_gpio();
    pll_tick <= 1'b0;
    frc_tick <= 1'b1;
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    rst(24'h000000, 24'h0000C0);
    chk({rng, sw_en, mon_en, pll_en, in_en, oo, ooe}, 7'b0000011);
    cnt(2, 32, 16);
    gpio_out <= 1'b0;
    idle(1);
    #1 chk({oo, ooe}, 2'b01);
    @(posedge clk_sys);
    // switching is off here: the request is taken but the group must stay put
    wr(4'h1, 8'h78); wr(4'h1, 8'h9A); wr(4'h1, 8'h01);
    wr(4'h0, 8'h46); wr(4'h0, 8'h57); wr(4'h0, 8'h01); idle(3);
    rd(4'h1); chk(rd_v, 8'h01);
  endtask

  // external clock with clock out: pin two toggles once per oscillator cycle
  task automatic t_ext_clock_out();
    int c;
    logic p;
    run <= 1'b1;
    rst(24'h000002, 24'h000004);
    chk({sw_en, mon_en, in_en, fb_en, ooe}, 5'b11101);
    cnt(2, 80, 10);
    c = 0;
    #1 p = oo;
    repeat (80) begin
      @(posedge clk_sys);
      #1 c += (oo != p);
      p = oo;
    end
    chk(8'(c), 8'h14);
    @(posedge clk_sys);
  endtask

  // crystal restart: 1024 oscillator cycles at 4 system cycles each
  task automatic t_crystal();
    int w;
    run <= 1'b1;
    rst(24'h000002, 24'h000082);
    chk({sw_en, mon_en, fb_en, in_en}, 4'b0011);
    repeat (2) begin
      idle(4040);
      #1 chk({7'h0, rel}, 8'h00);
      w = 0;
      while (rel !== 1'b1 && w < 100) begin
        @(posedge clk_sys);
        w++;
      end
      chk({7'h0, rel}, 8'h01);
      wake_pulse <= 1'b1;
      @(posedge clk_sys);
      wake_pulse <= 1'b0;
    end
  endtask

  initial begin
    t_ext_pll();
    t_unlock();
    t_frc_gpio();
    t_ext_clock_out();
    t_crystal();
    stop_test();
  end

  // whole run is near 9000 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
endmodule // csc_clock_source_config_tb
